// File: hdl/dual_timer.sv
// Two timer/counters with mode, control and count registers.
`timescale 1ns/1ps
`include "timer_defs.svh"
module dual_timer
  import timer_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // Special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrWrEn,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  // External pins
  input  wire logic       timerZeroCountPin,
  input  wire logic       timerOneCountPin,
  input  wire logic       extIrqZeroPin,
  input  wire logic       extIrqOnePin,
  // Port latch bits of the alternate pins
  input  wire logic       countLatchZero,
  input  wire logic       countLatchOne,
  input  wire logic       irqLatchZero,
  input  wire logic       irqLatchOne,
  // Interrupt vectoring
  input  wire logic       vectorAckZero,
  input  wire logic       vectorAckOne,
  output logic            timerZeroOverflowFlag,
  output logic            timerOneOverflowFlag
);

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  phase_if ph ();

  machine_cycle_gen u_gen (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .ph   (ph.gen)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] timerMode_q;
  logic [7:0] timerMode_d;
  logic [7:0] timerControl_q;
  logic [7:0] timerControl_d;
  logic [7:0] countLow_q  [2];
  logic [7:0] countLow_d  [2];
  logic [7:0] countHigh_q [2];
  logic [7:0] countHigh_d [2];
  logic [1:0] sample_q;
  logic [1:0] sample_d;
  logic [1:0] edgePend_q;
  logic [1:0] edgePend_d;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;

  logic [1:0] countPin;
  logic [1:0] irqPin;
  logic [1:0] gateBit;
  logic [1:0] ctBit;
  logic [1:0] runBit;
  logic [1:0] ackIn;
  mode_t      mode [2];

  assign ackIn = {vectorAckOne, vectorAckZero};

  // ----------------------------------------------------------------
  // Per-channel field and pin decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      localparam int FB = g * `MODE_FIELD_WIDTH;
      assign gateBit[g] = timerMode_q[FB + `MODE_GATE_BIT];
      assign ctBit[g]   = timerMode_q[FB + `MODE_CT_BIT];
      assign mode[g]    = mode_t'(timerMode_q[FB + `MODE_SEL_LSB +: 2]);
    end
  endgenerate

  assign runBit[0]   = timerControl_q[`CTRL_RUN_ZERO];
  assign runBit[1]   = timerControl_q[`CTRL_RUN_ONE];
  // An alternate pin whose latch holds 0 reads as stuck low.
  assign countPin[0] = timerZeroCountPin & countLatchZero;
  assign countPin[1] = timerOneCountPin & countLatchOne;
  assign irqPin[0]   = extIrqZeroPin & irqLatchZero;
  assign irqPin[1]   = extIrqOnePin & irqLatchOne;

  // ----------------------------------------------------------------
  // One count step in a given mode
  // ----------------------------------------------------------------
  // Only the mode decides how wide the count is and where it rolls over,
  // so both timers share this one description of a step.
  function automatic step_t countStep(mode_t m, logic [7:0] hi,
                                      logic [7:0] lo);
    step_t r;
    r.ovf = 1'b0;
    r.hi  = hi;
    r.lo  = lo;
    unique case (m)
      MODE_PRESCALED: begin
        // Upper three low-byte bits are left untouched.
        r.lo[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == `PRESCALE_MAX) begin
          r.hi  = hi + `BYTE_ONE;
          r.ovf = (hi == `BYTE_MAX);
        end
      end
      MODE_WIDE: begin
        {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h00001;
      end
      MODE_RELOAD: begin
        if (lo == `BYTE_MAX) begin
          r.lo  = hi;
          r.ovf = 1'b1;
        end else begin
          r.lo  = lo + `BYTE_ONE;
        end
      end
      MODE_SPLIT: begin
        r.lo  = lo + `BYTE_ONE;
        r.ovf = (lo == `BYTE_MAX);
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [1:0] enable;
  logic [1:0] ovfSet;
  logic       splitZero;
  step_t      st;

  always_comb begin
    timerMode_d    = timerMode_q;
    timerControl_d = timerControl_q;
    countLow_d     = countLow_q;
    countHigh_d    = countHigh_q;
    sample_d       = sample_q;
    edgePend_d     = edgePend_q;
    enable         = 2'b00;
    ovfSet         = 2'b00;
    st             = '0;
    splitZero      = (mode[0] == MODE_SPLIT);

    // Pin sampling: remember the last sample and flag a 1-to-0 pair.
    if (ph.samplePhase) begin
      for (int c = 0; c < 2; c++) begin
        edgePend_d[c] = sample_q[c] & ~countPin[c];
        sample_d[c]   = countPin[c];
      end
    end

    if (ph.updatePhase) begin
      for (int c = 0; c < 2; c++) begin
        // Gate clear ignores the pin; gate set needs it high.
        enable[c] = runBit[c] & (~gateBit[c]
                                 | irqPin[c]);
        if (ctBit[c]) begin
          enable[c] = enable[c] & edgePend_q[c];
        end
      end
      // In split mode timer one gives up its run bit; gate and ct bits still apply, and its own split mode stops it.
      if (splitZero) begin
        enable[1] = (~gateBit[1] | irqPin[1]) & (~ctBit[1] | edgePend_q[1]);
      end
      if (mode[1] == MODE_SPLIT) begin
        enable[1] = 1'b0;
      end
      for (int c = 0; c < 2; c++) begin
        if (enable[c]) begin
          st = countStep(mode[c], countHigh_q[c], countLow_q[c]);
          countLow_d[c]  = st.lo;
          countHigh_d[c] = st.hi;
          // Timer one's overflow cannot raise its flag in split mode.
          if (c == 0 || !splitZero) begin
            ovfSet[c] = st.ovf;
          end
        end
      end
      // Split mode high byte: machine cycles under timer one's run bit.
      if (splitZero && runBit[1]) begin
        countHigh_d[0] = countHigh_q[0] + `BYTE_ONE;
        ovfSet[1]      = (countHigh_q[0] == `BYTE_MAX);
      end
      // A pending edge is spent here even when the timer is gated off,
      // so an edge seen while disabled is never counted later.
      edgePend_d = 2'b00;
    end

    // Vector acknowledge clears a flag.
    if (ackIn[0]) begin
      timerControl_d[`CTRL_FLAG_ZERO] = 1'b0;
    end
    if (ackIn[1]) begin
      timerControl_d[`CTRL_FLAG_ONE] = 1'b0;
    end

    // Register writes; count writes override the increment above.
    if (sfrWrEn) begin
      unique case (sfrAddr)
        `ADDR_TIMER_CONTROL: timerControl_d = sfrWrData;
        `ADDR_TIMER_MODE:    timerMode_d    = sfrWrData;
        `ADDR_ZERO_LOW:      countLow_d[0]  = sfrWrData;
        `ADDR_ONE_LOW:       countLow_d[1]  = sfrWrData;
        `ADDR_ZERO_HIGH:     countHigh_d[0] = sfrWrData;
        `ADDR_ONE_HIGH:      countHigh_d[1] = sfrWrData;
        default: ;
      endcase
    end

    // A hardware overflow wins over any clear in the same cycle.
    if (ovfSet[0]) begin
      timerControl_d[`CTRL_FLAG_ZERO] = 1'b1;
    end
    if (ovfSet[1]) begin
      timerControl_d[`CTRL_FLAG_ONE] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timerMode_q    <= `RST_TIMER_MODE;
      timerControl_q <= `RST_TIMER_CONTROL;
      countLow_q     <= '{`RST_COUNT_BYTE, `RST_COUNT_BYTE};
      countHigh_q    <= '{`RST_COUNT_BYTE, `RST_COUNT_BYTE};
      sample_q       <= 2'b00;
      edgePend_q     <= 2'b00;
    end else if (ce) begin
      timerMode_q    <= timerMode_d;
      timerControl_q <= timerControl_d;
      countLow_q     <= countLow_d;
      countHigh_q    <= countHigh_d;
      sample_q       <= sample_d;
      edgePend_q     <= edgePend_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reads see the registers before this edge's writes and increments,
  // so a read and a write in one cycle return the old value.
  always_comb begin
    rdData_d = rdData_q;
    if (sfrRdEn) begin
      unique case (sfrAddr)
        `ADDR_TIMER_CONTROL: rdData_d = timerControl_q;
        `ADDR_TIMER_MODE:    rdData_d = timerMode_q;
        `ADDR_ZERO_LOW:      rdData_d = countLow_q[0];
        `ADDR_ONE_LOW:       rdData_d = countLow_q[1];
        `ADDR_ZERO_HIGH:     rdData_d = countHigh_q[0];
        `ADDR_ONE_HIGH:      rdData_d = countHigh_q[1];
        default:             rdData_d = `READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_q <= `READ_UNMAPPED;
    end else if (ce) begin
      rdData_q <= rdData_d;
    end
  end

  assign sfrRdData             = rdData_q;
  assign timerZeroOverflowFlag = timerControl_q[`CTRL_FLAG_ZERO];
  assign timerOneOverflowFlag  = timerControl_q[`CTRL_FLAG_ONE];

endmodule

// File: hdl/machine_cycle_gen.sv
// Divides the core clock into machine cycles and marks two phases.
`timescale 1ns/1ps
`include "timer_defs.svh"
module machine_cycle_gen
  import timer_pkg::*;
#(
  parameter int CLOCKS = `CLOCKS_PER_MCYCLE
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Phase strobes
  phase_if.gen      ph
);

  logic [3:0] idx_q;
  logic [3:0] idx_d;

  always_comb begin
    if (idx_q == 4'(CLOCKS - 1)) begin
      idx_d = 4'h0;
    end else begin
      idx_d = idx_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx_q <= 4'h0;
    end else if (ce) begin
      idx_q <= idx_d;
    end
  end

  assign ph.samplePhase = ce && (idx_q == 4'(`SAMPLE_PHASE_IDX));
  assign ph.updatePhase = ce && (idx_q == 4'(`UPDATE_PHASE_IDX));

endmodule

// File: pkg/phase_if.sv
// Machine cycle phase strobes passed from the phase generator.
`timescale 1ns/1ps
interface phase_if;
  logic samplePhase;
  logic updatePhase;

  modport gen (output samplePhase, output updatePhase);
  modport user (input samplePhase, input updatePhase);
endinterface

// File: pkg/timer_defs.svh
// Register addresses, bit positions, reset values and phase counts.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_TIMER_MODE    8'h89
`define ADDR_ZERO_LOW      8'h8A
`define ADDR_ONE_LOW       8'h8B
`define ADDR_ZERO_HIGH     8'h8C
`define ADDR_ONE_HIGH      8'h8D

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TIMER_CONTROL  8'h00
`define RST_TIMER_MODE     8'h00
`define RST_COUNT_BYTE     8'h00
`define READ_UNMAPPED      8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MODE_FIELD_WIDTH   4
`define MODE_SEL_LSB       0
`define MODE_CT_BIT        2
`define MODE_GATE_BIT      3
`define CTRL_RUN_ZERO      4
`define CTRL_FLAG_ZERO     5
`define CTRL_RUN_ONE       6
`define CTRL_FLAG_ONE      7
`define CTRL_EXT_LSB       0
`define CTRL_EXT_WIDTH     4

// ----------------------------------------------------------------
// Machine cycle timing, in core clocks
// ----------------------------------------------------------------
`define CLOCKS_PER_MCYCLE  12
`define SAMPLE_PHASE_IDX   9
`define UPDATE_PHASE_IDX   4

// ----------------------------------------------------------------
// Count constants
// ----------------------------------------------------------------
`define PRESCALE_MAX       5'h1F
`define BYTE_MAX           8'hFF
`define BYTE_ONE           8'h01

`endif

// File: pkg/timer_pkg.sv
// Types shared by the timer/counter design files.
package timer_pkg;

  // Order matches the two-bit mode field encoding 00 to 11.
  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_WIDE,
    MODE_RELOAD,
    MODE_SPLIT
  } mode_t;

  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } step_t;

endpackage

// File: verification/dual_timer_properties.sv
// Port-level assertions for the dual timer/counter.
`timescale 1ns/1ps
module dual_timer_properties (
  // Clock, reset and enable
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData,
  // Flags and acknowledges
  input wire logic       vectorAckZero,
  input wire logic       vectorAckOne,
  input wire logic       timerZeroOverflowFlag,
  input wire logic       timerOneOverflowFlag
);
  // Flags are set by hardware only around the update phase; a clock of margin on each
  // side keeps the check safe whichever edge the flag register uses.
  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic       near;
  logic       ctrlWr;
  always_comb begin
    phase_d = (phase_q == 4'hB || !nrst) ? 4'h0 : phase_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (ce) begin
      phase_q <= phase_d;
    end
  end
  assign near   = phase_q >= 4'h3 && phase_q <= 4'h5;
  assign ctrlWr = ce && sfrWrEn && sfrAddr == 8'h88;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_clear: assert property ($rose(nrst) |->
    sfrRdData == 8'h00 && !timerZeroOverflowFlag && !timerOneOverflowFlag)
    else $error("outputs not clear after reset");
  a_unmapped_zero: assert property (ce && sfrRdEn &&
    (sfrAddr < 8'h88 || sfrAddr > 8'h8D) |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!(ce && sfrRdEn) |=>
    $stable(sfrRdData)) else $error("read data moved");
  a_read_flags: assert property (ce && sfrRdEn &&
    sfrAddr == 8'h88 |=>
    sfrRdData[7] == $past(timerOneOverflowFlag) &&
    sfrRdData[5] == $past(timerZeroOverflowFlag))
    else $error("control read disagrees with flags");
  a_zero_rise: assert property (ce && !near && !ctrlWr &&
    !timerZeroOverflowFlag |=> !timerZeroOverflowFlag)
    else $error("flag zero rose off phase");
  a_one_rise: assert property (ce && !near && !ctrlWr &&
    !timerOneOverflowFlag |=> !timerOneOverflowFlag)
    else $error("flag one rose off phase");
  a_ack_zero: assert property (ce && vectorAckZero && !near &&
    !ctrlWr |=> !timerZeroOverflowFlag) else $error("flag zero kept");
  a_ack_one: assert property (ce && vectorAckOne && !near &&
    !ctrlWr |=> !timerOneOverflowFlag) else $error("flag one kept");
  c_zero_ovf: cover property ($rose(timerZeroOverflowFlag));
  c_one_ovf: cover property ($rose(timerOneOverflowFlag));
  c_ack: cover property (vectorAckZero && timerZeroOverflowFlag);
endmodule

// File: verification/dual_timer_tb.sv
// Self-checking testbench for the dual timer/counter.
`timescale 1ns/1ps
module dual_timer_tb;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdData;
  logic       sfrWrEn = 1'b0;
  logic       sfrRdEn = 1'b0;
  logic       irqLatchOne = 1'b1;
  logic       ce = 1'b1;
  logic       ack0 = 1'b0;
  logic       ack1 = 1'b0;
  logic       cnt0, cnt1, irq0, irq1, flag0, flag1;
  int         err_count = 0;
  int         n_tests = 0;
  dual_timer dut (
    .clk(clk), .nrst(nrst), .ce(ce), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .timerZeroCountPin(cnt0),
    .timerOneCountPin(cnt1), .extIrqZeroPin(irq0), .extIrqOnePin(irq1),
    .countLatchZero(1'b1), .countLatchOne(1'b1), .irqLatchZero(1'b1),
    .irqLatchOne(irqLatchOne), .vectorAckZero(ack0),
    .vectorAckOne(ack1), .timerZeroOverflowFlag(flag0),
    .timerOneOverflowFlag(flag1));
  pin_source src0 (.clk(clk), .countPin(cnt0), .gatePin(irq0));
  pin_source src1 (.clk(clk), .countPin(cnt1), .gatePin(irq1));
  initial forever #50 clk = ~clk;
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr   = a;
    sfrWrData = d;
    sfrWrEn   = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(negedge clk);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    check(what, exp, sfrRdData);
  endtask
  // Runs for exactly n machine cycles; the stop write carries the flags
  // read just before it so that stopping never wipes an overflow.
  task automatic run_for(input logic [7:0] ctrl, input int n);
    wr(8'h88, ctrl);
    repeat (12 * n - 1) @(negedge clk);
    sfrWrData = {flag1, 1'b0, flag0, 5'h00};
    sfrWrEn   = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
  endtask
  task automatic t_regs();
    rd(8'h88, 8'h00, "control");
    rd(8'h89, 8'h00, "mode");
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h00, "unmapped");
    wr(8'h89, 8'hA5);
    rd(8'h89, 8'hA5, "mode rw");
    wr(8'h88, 8'h0F);
    rd(8'h88, 8'h0F, "control low");
    wr(8'h88, 8'h00);
  endtask
  task automatic t_mode(input logic [7:0] m, input logic [7:0] lo,
                        input logic [7:0] hi, input int n,
                        input logic [7:0] eLo, input logic [7:0] eHi);
    wr(8'h89, m);
    wr(8'h8A, lo);
    wr(8'h8C, hi);
    run_for(8'h10, n);
    check("flag0 set", 8'h01, {7'h00, flag0});
    rd(8'h8A, eLo, "low0");
    rd(8'h8C, eHi, "high0");
    ack0 = 1'b1;
    @(negedge clk);
    ack0 = 1'b0;
    check("flag0 clear", 8'h00, {7'h00, flag0});
  endtask
  task automatic t_pins();
    wr(8'h89, 8'hD5);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    src1.set_gate(1'b1);
    wr(8'h88, 8'h50);
    fork
      src0.pulses(3, 12);
      src1.pulses(3, 15);
    join
    rd(8'h8A, 8'h03, "edges0");
    rd(8'h8B, 8'h03, "gated edges1");
    irqLatchOne = 1'b0;
    fork
      src0.pulses(2, 12);
      src1.pulses(2, 12);
    join
    rd(8'h8A, 8'h05, "ungated edges0");
    rd(8'h8B, 8'h03, "latched gate1");
    wr(8'h88, 8'h00);
  endtask
  task automatic t_split();
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFF);
    run_for(8'h40, 1);
    check("flag1 set", 8'h01, {7'h00, flag1});
    rd(8'h8C, 8'h00, "split high0");
    rd(8'h8A, 8'h05, "split low0");
    rd(8'h8B, 8'h03, "held low1");
    ack1 = 1'b1;
    @(negedge clk);
    ack1 = 1'b0;
    check("flag1 clear", 8'h00, {7'h00, flag1});
  endtask
  // Holds the clock enable low in mid-run, with a write that must be
  // ignored, then lets exactly two enabled machine cycles count.
  task automatic t_freeze();
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    ce = 1'b0;
    wr(8'h8A, 8'h55);
    repeat (34) @(negedge clk);
    ce      = 1'b1;
    sfrAddr = 8'h88;
    repeat (23) @(negedge clk);
    sfrWrData = {flag1, 1'b0, flag0, 5'h00};
    sfrWrEn   = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
    check("frozen flag0", 8'h01, {7'h00, flag0});
    rd(8'h8A, 8'h00, "frozen low0");
    rd(8'h8C, 8'h00, "frozen high0");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_mode(8'h00, 8'h1E, 8'hFF, 2, 8'h00, 8'h00);
    t_mode(8'h01, 8'hFE, 8'hFF, 3, 8'h01, 8'h00);
    t_mode(8'h02, 8'hFF, 8'h80, 2, 8'h81, 8'h80);
    t_pins();
    t_split();
    t_freeze();
    close_out();
  end
  initial begin
    #500000;
    err_count++;
    close_out();
  end
endmodule
bind dual_timer dual_timer_properties chk (
  .clk(clk), .nrst(nrst), .ce(ce), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
  .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
  .vectorAckZero(vectorAckZero), .vectorAckOne(vectorAckOne),
  .timerZeroOverflowFlag(timerZeroOverflowFlag),
  .timerOneOverflowFlag(timerOneOverflowFlag));

// File: verification/pin_source.sv
// Behavioural source of one count pin and one gate pin.
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic clk,
  // Pins
  output logic     countPin,
  output logic     gatePin
);
  // Idling high makes the first low level a real falling edge.
  initial countPin = 1'b1;
  initial gatePin = 1'b0;
  // Shorter levels than a machine cycle may be missed by the timer, so
  // hold is never below twelve clocks; larger values model a slow source.
  task automatic set_gate(input logic v);
    gatePin = v;
  endtask
  task automatic pulses(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(negedge clk);
      countPin = 1'b0;
      repeat (hold) @(negedge clk);
      countPin = 1'b1;
    end
    repeat (2 * hold) @(negedge clk);
  endtask
endmodule
